// ### opks_sequencer.sv
// apb slave guarding one-time memory programming behind an ordered key sequence
//
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "opks_defines.svh"

// Functional notes
// - Key stages A, B and C sit at indices 0x150, 0x151 and 0x152, each one writable byte.
// - Programming starts only once both the first confirmation and the stage A to D key sequence are complete.
// - Every key register reads back 0x00 regardless of what was written.
// - Once unlocked, the very next accepted register write drops the unlock; a write refused with pslverr keeps it.
// - Key stage D sits at index 0x153 with the same byte layout and zero readback.
module opks_sequencer
  import opks_pkg::*;
#(
  parameter int         ADDR_W    = 12,
  parameter logic [7:0] KEY_ONE   = `OPKS_DEF_KEY_ONE,  // arbitrary value
  parameter logic [7:0] KEY_A     = `OPKS_DEF_KEY_A,    // arbitrary value
  parameter logic [7:0] KEY_B     = `OPKS_DEF_KEY_B,    // arbitrary value
  parameter logic [7:0] KEY_C     = `OPKS_DEF_KEY_C,    // arbitrary value
  parameter logic [7:0] KEY_D     = `OPKS_DEF_KEY_D     // arbitrary value
) (
  // clock and reset
  input  wire logic              core_clk,
  input  wire logic              resetn,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  // programming engine
  input  wire logic              program_busy,
  output logic                   program_start,
  output logic                   program_unlocked
);

  // ============================================================
  // decode
  function automatic logic [9:0] word_index(input logic [ADDR_W-1:0] a);
    word_index = 10'(a[ADDR_W-1:2]);
  endfunction : word_index

  function automatic logic key_match(input logic [7:0] d, input logic [7:0] k);
    key_match = (d == k);
  endfunction : key_match

  wire logic [9:0] idx         = word_index(paddr);
  wire logic       hit_a       = (idx == `OPKS_IDX_STAGE_A);
  wire logic       hit_b       = (idx == `OPKS_IDX_STAGE_B);
  wire logic       hit_c       = (idx == `OPKS_IDX_STAGE_C);
  wire logic       hit_d       = (idx == `OPKS_IDX_STAGE_D);
  wire logic       hit_key     = hit_a | hit_b | hit_c | hit_d;
  wire logic       hit_one     = (idx == `OPKS_IDX_CONFIRM_ONE);
  wire logic       hit_ctrl    = (idx == `OPKS_IDX_PROG_CTRL);
  wire logic       hit_stat    = (idx == `OPKS_IDX_STATUS);
  wire logic       mapped      = hit_key | hit_one | hit_ctrl | hit_stat;
  wire logic       aligned     = (paddr[1:0] == 2'b00);
  // writes must carry the low byte lane; status is read only
  wire logic       wr_ok       = pstrb[0] & ~hit_stat;
  wire logic       bad_access  = ~mapped | ~aligned | (pwrite & ~wr_ok);

  // ============================================================
  // bus phases
  wire logic       setup_ph    = psel & ~penable;
  wire logic       access_done = psel & penable & pready;
  wire logic       wr_commit   = access_done & pwrite & ~pslverr;
  wire logic [7:0] wbyte       = pwdata[7:0];

  // ============================================================
  // state
  opks_state_t state;
  opks_state_t next_state;
  logic        first_done;
  logic        next_first_done;
  logic        go_req;
  logic        fire;

  // go bit of the control register, only honoured when armed and idle engine
  assign go_req = wr_commit & hit_ctrl & wbyte[`OPKS_CTRL_GO_BIT];
  assign fire   = go_req & (state == OPKS_UNLOCKED) & first_done & ~program_busy;

  // ============================================================
  // key sequence
  always_comb begin
    next_state = state;
    if (wr_commit) begin
      case (state)
        OPKS_UNLOCKED: begin
          next_state = OPKS_IDLE;
        end
        OPKS_IDLE: begin
          next_state = (hit_a & key_match(wbyte, KEY_A)) ? OPKS_GOT_A : OPKS_IDLE;
        end
        OPKS_GOT_A: begin
          if (hit_b & key_match(wbyte, KEY_B)) begin
            next_state = OPKS_GOT_B;
          end else begin
            next_state = (hit_a & key_match(wbyte, KEY_A)) ? OPKS_GOT_A : OPKS_IDLE;
          end
        end
        OPKS_GOT_B: begin
          if (hit_c & key_match(wbyte, KEY_C)) begin
            next_state = OPKS_GOT_C;
          end else begin
            next_state = (hit_a & key_match(wbyte, KEY_A)) ? OPKS_GOT_A : OPKS_IDLE;
          end
        end
        OPKS_GOT_C: begin
          if (hit_d & key_match(wbyte, KEY_D)) begin
            next_state = OPKS_UNLOCKED;
          end else begin
            next_state = (hit_a & key_match(wbyte, KEY_A)) ? OPKS_GOT_A : OPKS_IDLE;
          end
        end
        default: begin
          next_state = OPKS_IDLE;
        end
      endcase
    end
  end

  // ============================================================
  // first confirmation
  // a used or refused first confirmation must be given again
  always_comb begin
    next_first_done = first_done;
    if (wr_commit & hit_one) begin
      next_first_done = key_match(wbyte, KEY_ONE);
    end else if (go_req) begin
      next_first_done = 1'b0;
    end
  end

  // ============================================================
  // read mux
  wire logic [31:0] stat_word = {
    25'h0000000,
    fire | program_start,
    program_busy,
    first_done,
    (state == OPKS_UNLOCKED),
    state
  };

  // key and control registers read zero so keys never leak
  wire logic [31:0] read_word = hit_stat ? stat_word : `OPKS_READ_ZERO;

  // ============================================================
  // registers
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state      <= OPKS_IDLE;
      first_done <= 1'b0;
    end else begin
      state      <= next_state;
      first_done <= next_first_done;
    end
  end

  // no wait states: pready rises in the access phase after every setup
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= `OPKS_READ_ZERO;
    end else begin
      pready  <= setup_ph;
      pslverr <= setup_ph & bad_access;
      prdata  <= (setup_ph & ~pwrite & ~bad_access) ? read_word : `OPKS_READ_ZERO;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      program_start    <= 1'b0;
      program_unlocked <= 1'b0;
    end else begin
      program_start    <= fire;
      program_unlocked <= (next_state == OPKS_UNLOCKED) & next_first_done;
    end
  end

endmodule : opks_sequencer
`default_nettype wire

// ### opks_defines.svh
// register indices, field positions, reset values and key defaults for the program key sequencer
`ifndef OPKS_DEFINES_SVH
`define OPKS_DEFINES_SVH

// ============================================================
// register indices (byte address is four times the index)
`define OPKS_IDX_STAGE_A      10'h150
`define OPKS_IDX_STAGE_B      10'h151
`define OPKS_IDX_STAGE_C      10'h152
`define OPKS_IDX_STAGE_D      10'h153
`define OPKS_IDX_CONFIRM_ONE  10'h15c
`define OPKS_IDX_PROG_CTRL    10'h15d
`define OPKS_IDX_STATUS       10'h15e

// ============================================================
// field positions
`define OPKS_CTRL_GO_BIT      0
`define OPKS_STAT_STAGE_LSB   0
`define OPKS_STAT_STAGE_MSB   2
`define OPKS_STAT_UNLOCKED    3
`define OPKS_STAT_FIRST_DONE  4
`define OPKS_STAT_BUSY        5
`define OPKS_STAT_STARTED     6

// ============================================================
// reset values and arbitrary key defaults
`define OPKS_KEY_RESET        8'h00
`define OPKS_READ_ZERO        32'h0000_0000
`define OPKS_DEF_KEY_ONE      8'h5a
`define OPKS_DEF_KEY_A        8'h11
`define OPKS_DEF_KEY_B        8'h22
`define OPKS_DEF_KEY_C        8'h33
`define OPKS_DEF_KEY_D        8'h44

`endif

// ### opks_pkg.sv
// types shared by the program key sequencer
package opks_pkg;

  // ============================================================
  // sequence states
  typedef enum logic [2:0] {
    OPKS_IDLE     = 3'b000,
    OPKS_GOT_A    = 3'b001,
    OPKS_GOT_B    = 3'b010,
    OPKS_GOT_C    = 3'b011,
    OPKS_UNLOCKED = 3'b100
  } opks_state_t;

endpackage : opks_pkg

// ### opks_monitor.sv
// assertion checker for the program key sequencer
`timescale 1ns/10ps
`default_nettype none
// ====================
// checker
module opks_monitor #(parameter int ADDR_W = 12, parameter logic [7:0] KEY_D = 8'h44) (
  // apb
  input wire logic core_clk, resetn, psel, penable, pwrite, pready, pslverr,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata, prdata,
  input wire logic [3:0] pstrb,
  // engine
  input wire logic program_start, program_unlocked
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  wire done_w = psel & penable & pready;
  wire key_w = paddr[11:4] == 8'h54 && paddr[1:0] == 2'h0;
  wire keyd_w = key_w && paddr[3:2] == 2'h3;
  logic d_ok_q;
  // helper flop: a good stage d commit one cycle back
  always_ff @(posedge core_clk) d_ok_q <= resetn & done_w & pwrite & ~pslverr & keyd_w
                                          & (pwdata[7:0] == KEY_D);
  sequence s_commit; done_w && pwrite && !pslverr; endsequence
  sequence s_setup; psel && !penable; endsequence
  property p_ready; s_setup |=> pready; endproperty
  property p_key_wr; done_w && pwrite && pstrb[0] && key_w |-> !pslverr; endproperty
  property p_key_rd; done_w && !pwrite && key_w |-> prdata == 32'h0 && !pslverr; endproperty
  property p_key_d; done_w && keyd_w && pstrb[0] |-> !pslverr; endproperty
  property p_drop; program_unlocked ##0 s_commit |=> !program_unlocked; endproperty
  property p_unlock; $rose(program_unlocked) |-> d_ok_q; endproperty
  property p_start; $rose(program_start) |-> $past(program_unlocked); endproperty
  property p_pulse; program_start |=> !program_start; endproperty
  a_ready: assert property (p_ready) else $error("no ready after setup");
  a_key_wr: assert property (p_key_wr) else $error("key write refused");
  a_key_rd: assert property (p_key_rd) else $error("key read not zero");
  a_key_d: assert property (p_key_d) else $error("stage d refused");
  a_drop: assert property (p_drop) else $error("unlock kept after write");
  a_unlock: assert property (p_unlock) else $error("unlock without stage d");
  a_start: assert property (p_start) else $error("start while locked");
  a_pulse: assert property (p_pulse) else $error("start too long");
endmodule : opks_monitor
bind opks_sequencer opks_monitor #(.ADDR_W(ADDR_W), .KEY_D(KEY_D)) i_opks_monitor (
  .core_clk(core_clk), .resetn(resetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .pready(pready), .pslverr(pslverr), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pstrb(pstrb), .program_start(program_start), .program_unlocked(program_unlocked));
`default_nettype wire

// ### testbench.sv
// self-checking bench for the program key sequencer
`timescale 1ns/10ps
`default_nettype none
// ====================
// bench
module testbench;
  typedef struct packed {logic [9:0] idx; logic [7:0] dat; logic [1:0] ex;} opks_row_t;
  logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0, program_busy = 0;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hf;
  wire pready, pslverr, program_start, program_unlocked;
  wire [31:0] prdata;
  logic [31:0] rd;
  logic err;
  int miscompares = 0, n_compared = 0;
  // ex is {unlocked, start} just after the commit
  opks_row_t rows [22] = '{
    '{10'h15c, 8'h5a, 2'h0}, '{10'h150, 8'h11, 2'h0}, '{10'h151, 8'h22, 2'h0},
    '{10'h152, 8'h33, 2'h0}, '{10'h153, 8'h44, 2'h2}, '{10'h15d, 8'h01, 2'h1},
    '{10'h15c, 8'h5a, 2'h0}, '{10'h150, 8'h11, 2'h0}, '{10'h152, 8'h33, 2'h0},
    '{10'h151, 8'h22, 2'h0}, '{10'h152, 8'h33, 2'h0}, '{10'h153, 8'h44, 2'h0},
    '{10'h150, 8'h11, 2'h0}, '{10'h151, 8'h22, 2'h0}, '{10'h152, 8'h33, 2'h0},
    '{10'h153, 8'h55, 2'h0}, '{10'h150, 8'h11, 2'h0}, '{10'h151, 8'h22, 2'h0},
    '{10'h152, 8'h33, 2'h0}, '{10'h153, 8'h44, 2'h2}, '{10'h150, 8'h11, 2'h0},
    '{10'h15d, 8'h01, 2'h0}};
  opks_sequencer i_opks_sequencer (.core_clk(core_clk), .resetn(resetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .program_busy(program_busy),
    .program_start(program_start), .program_unlocked(program_unlocked));
  initial forever #2.5 core_clk = ~core_clk;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check
  task automatic print_verdict;
    if (miscompares == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : print_verdict
  // one apb transfer, held until ready is seen at a rising edge
  task automatic apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
    int n;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge core_clk);
    penable <= 1'b1;
    for (n = 0; n < 8; n++) begin
      @(posedge core_clk);
      if (pready === 1'b1) break;
    end
    if (n == 8) begin
      miscompares++;
      print_verdict();
    end else begin
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask : apb
  initial begin
    repeat (12) @(posedge core_clk);
    check(32'({pready, pslverr, program_start, program_unlocked}), 32'h0);
    resetn <= 1'b1;
    foreach (rows[i]) begin
      apb(1'b1, rows[i].idx, rows[i].dat);
      @(negedge core_clk);
      check(32'({program_unlocked, program_start}), 32'(rows[i].ex));
    end
    for (int k = 0; k < 4; k++) begin
      apb(1'b0, 10'h150 + 10'(k), 8'h0);
      check(rd, 32'h0);
      check(32'(err), 32'h0);
    end
    apb(1'b0, 10'h100, 8'h0);
    check(32'(err), 32'h1);
    // back to back unlock, then a refused write must not break it
    for (int k = 0; k < 5; k++) apb(1'b1, rows[k].idx, rows[k].dat);
    pstrb <= 4'h0;
    apb(1'b1, 10'h150, 8'h11);
    pstrb <= 4'hf;
    program_busy <= 1'b1;
    check(32'(err), 32'h1);
    @(negedge core_clk);
    check(32'(program_unlocked), 32'h1);
    apb(1'b1, 10'h15d, 8'h01);
    @(negedge core_clk);
    check(32'({program_unlocked, program_start}), 32'h0);
    check(32'(program_start), 32'h0);
    // status: idle, locked, first confirmation used up, engine busy
    apb(1'b0, 10'h15e, 8'h0);
    check(rd, 32'h0000_0020);
    check(32'(err), 32'h0);
    print_verdict();
  end
endmodule : testbench
`default_nettype wire
